// >>> dmp_defines.svh
// Constants for the multiply-accumulate prefetch datapath
//
// Behaviour
// RQ1: Prefetch-only does no arithmetic, keeps accumulator, still performs fetches.
// RQ2: Multiply loads product into selected accumulator, replacing old contents.
// RQ3: Negated multiply loads negated product into selected accumulator.
// RQ4: Multiply-subtract subtracts product from selected accumulator.
// RQ5: Pointer increment is even literal -6..6 or a register value.
// RQ6: No X prefetch means no X access; X increment and destination ignored.
// RQ7: No Y prefetch means no Y access; Y increment and destination ignored.
// RQ8: X prefetch reads only X memory, Y prefetch only Y memory.
// RQ9: Prefetched word is written into nominated destination working register.
// RQ10: Write-back stores the non-target accumulator to nominated location.
// RQ11: Signed-by-signed multiply gives signed double-width product.
// RQ12: Signed-by-unsigned multiply treats second operand unsigned, signed result.
// RQ13: Signed-by-unsigned second operand comes from register or immediate literal.
// RQ14: Multiply-accumulate adds product to selected accumulator.
// RQ15: Prefetch reads at current pointer, then updates pointer same cycle.
`ifndef DMP_DEFINES_SVH
`define DMP_DEFINES_SVH
`define DMP_ACC_RESET 40'h00_0000_0000
`define DMP_PTR_RESET 16'h0000
`define DMP_INC_MIN (-6)
`define DMP_INC_MAX 6
`endif

// >>> dmp_pkg.sv
// Types for the multiply-accumulate prefetch datapath
package dmp_pkg;
    typedef enum logic [2:0] {
        dmp_op_prefetch = 3'h0,
        dmp_op_mpy = 3'h1,
        dmp_op_mpyn = 3'h2,
        dmp_op_msc = 3'h3,
        dmp_op_mac = 3'h4,
        dmp_op_mulss = 3'h5,
        dmp_op_mulsu = 3'h6
    } dmp_op_t;
endpackage : dmp_pkg

// >>> dmp_fetch_if.sv
// Prefetch channel bundle between datapath and fetch unit
interface dmp_fetch_if;
    logic go;
    logic inc_sel_reg;
    logic [3:0] inc_lit;
    logic [15:0] inc_reg;
    logic [15:0] ptr;
    logic [15:0] next_ptr;
    logic [15:0] rd_addr;
    logic rd_en;
    modport core (output go, inc_sel_reg, inc_lit, inc_reg, ptr, input next_ptr, rd_addr, rd_en);
    modport unit (input go, inc_sel_reg, inc_lit, inc_reg, ptr, output next_ptr, rd_addr, rd_en);
endinterface : dmp_fetch_if

// >>> dmp_fetch_unit.sv
// One prefetch address generator with pointer post-modify
module dmp_fetch_unit (
    dmp_fetch_if.unit f
);
    logic signed [15:0] step;
    always_comb begin
        // Literal is a signed even step, clamped to the legal range
        step = 16'(signed'(f.inc_lit));
        if (step > 16'sd6) begin
            step = 16'sd6;
        end
        if (step < -16'sd6) begin
            step = -16'sd6;
        end
        step[0] = 1'b0; // RQ5
        if (f.inc_sel_reg) begin
            step = f.inc_reg; // RQ5
        end
    end
    assign f.rd_en = f.go; // RQ6 RQ7
    assign f.rd_addr = f.ptr; // RQ15
    assign f.next_ptr = f.go ? 16'(f.ptr + step) : f.ptr; // RQ15
endmodule : dmp_fetch_unit

// >>> dmp_mac_datapath.sv
// Multiply-accumulate datapath with X/Y operand prefetch
`include "dmp_defines.svh"
module dmp_mac_datapath (
    input wire logic clock,
    input wire logic resetn,
    input wire logic issue,
    input wire dmp_pkg::dmp_op_t op,
    input wire logic acc_sel,
    input wire logic [15:0] opnd_a,
    input wire logic [15:0] opnd_b,
    input wire logic [15:0] imm_b,
    input wire logic use_imm_b,
    input wire logic x_fetch,
    input wire logic x_inc_sel_reg,
    input wire logic [3:0] x_inc_lit,
    input wire logic [15:0] x_inc_reg,
    input wire logic [3:0] x_dest,
    input wire logic y_fetch,
    input wire logic [3:0] y_inc_lit,
    input wire logic y_inc_sel_reg,
    input wire logic [15:0] y_inc_reg,
    input wire logic [3:0] y_dest,
    input wire logic wb_en,
    input wire logic [3:0] acc_writeback_target,
    input wire logic [15:0] x_rdata,
    input wire logic [15:0] y_rdata,
    output logic x_rd_en,
    output logic [15:0] x_rd_addr,
    output logic y_rd_en,
    output logic [15:0] y_rd_addr,
    output logic [15:0] x_ptr,
    output logic [15:0] y_ptr,
    output logic [39:0] acc_a,
    output logic [39:0] acc_b,
    output logic [31:0] mul_result,
    output logic reg_we_x,
    output logic [3:0] reg_waddr_x,
    output logic [15:0] reg_wdata_x,
    output logic reg_we_y,
    output logic [3:0] reg_waddr_y,
    output logic [15:0] reg_wdata_y,
    output logic wb_we,
    output logic [3:0] wb_addr,
    output logic [15:0] wb_data
);
    import dmp_pkg::*;

    // ------------------------------------------------------------
    // Address generators
    // ------------------------------------------------------------
    dmp_fetch_if xf();
    dmp_fetch_if yf();
    logic x_do;
    logic y_do;
    assign x_do = issue && x_fetch;
    assign y_do = issue && y_fetch;
    assign xf.go = x_do;
    assign xf.inc_sel_reg = x_inc_sel_reg;
    assign xf.inc_lit = x_inc_lit;
    assign xf.inc_reg = x_inc_reg;
    assign xf.ptr = x_ptr;
    assign yf.go = y_do;
    assign yf.inc_sel_reg = y_inc_sel_reg;
    assign yf.inc_lit = y_inc_lit;
    assign yf.inc_reg = y_inc_reg;
    assign yf.ptr = y_ptr;
    dmp_fetch_unit u_xf (.f(xf));
    dmp_fetch_unit u_yf (.f(yf));

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    logic [15:0] b_val;
    logic signed [39:0] prod;
    logic signed [31:0] prod_ss;
    logic signed [31:0] prod_su;
    logic [39:0] acc_sel_val;
    logic [39:0] next_acc_a;
    logic [39:0] next_acc_b;
    logic [39:0] next_tgt;
    logic [31:0] next_mul_result;
    logic next_x_rd_en;
    logic next_y_rd_en;
    logic [15:0] next_x_rd_addr;
    logic [15:0] next_y_rd_addr;
    logic [15:0] next_x_ptr;
    logic [15:0] next_y_ptr;
    logic x_pend;
    logic y_pend;
    logic [3:0] x_dest_q;
    logic [3:0] y_dest_q;
    logic next_wb_we;
    logic [3:0] next_wb_addr;
    logic [15:0] next_wb_data;
    logic [39:0] other_acc;

    always_comb begin
        b_val = use_imm_b ? imm_b : opnd_b; // RQ13
        prod_ss = 32'(signed'(opnd_a)) * 32'(signed'(opnd_b)); // RQ11
        prod_su = 32'($signed({{16{opnd_a[15]}}, opnd_a}) * $signed({16'h0000, b_val})); // RQ12
        prod = 40'(prod_ss);
        acc_sel_val = acc_sel ? acc_b : acc_a;
        other_acc = acc_sel ? acc_a : acc_b;
        next_tgt = acc_sel_val;
        next_mul_result = mul_result;
        unique case (op)
            dmp_op_prefetch: next_tgt = acc_sel_val; // RQ1
            dmp_op_mpy: next_tgt = prod; // RQ2
            dmp_op_mpyn: next_tgt = 40'(-prod); // RQ3
            dmp_op_msc: next_tgt = 40'(acc_sel_val - prod); // RQ4
            dmp_op_mac: next_tgt = 40'(acc_sel_val + prod); // RQ14
            dmp_op_mulss: next_mul_result = prod_ss; // RQ11
            dmp_op_mulsu: next_mul_result = prod_su; // RQ12
            default: next_tgt = acc_sel_val;
        endcase
        next_acc_a = acc_a;
        next_acc_b = acc_b;
        if (!issue) begin
            next_mul_result = mul_result;
        end else if (acc_sel) begin
            next_acc_b = next_tgt;
        end else begin
            next_acc_a = next_tgt;
        end
        next_x_rd_en = xf.rd_en; // RQ8
        next_x_rd_addr = x_do ? xf.rd_addr : x_rd_addr;
        next_x_ptr = xf.next_ptr; // RQ15
        next_y_rd_en = yf.rd_en; // RQ8
        next_y_rd_addr = y_do ? yf.rd_addr : y_rd_addr;
        next_y_ptr = yf.next_ptr; // RQ15
        next_wb_we = issue && wb_en && op inside {dmp_op_prefetch, dmp_op_msc, dmp_op_mac};
        next_wb_addr = next_wb_we ? acc_writeback_target : wb_addr;
        next_wb_data = next_wb_we ? other_acc[31:16] : wb_data; // RQ10
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            acc_a <= `DMP_ACC_RESET;
            acc_b <= `DMP_ACC_RESET;
            mul_result <= 32'h0000_0000;
            x_rd_en <= 1'b0;
            y_rd_en <= 1'b0;
            x_rd_addr <= `DMP_PTR_RESET;
            y_rd_addr <= `DMP_PTR_RESET;
            x_ptr <= `DMP_PTR_RESET;
            y_ptr <= `DMP_PTR_RESET;
            wb_we <= 1'b0;
            wb_addr <= 4'h0;
            wb_data <= 16'h0000;
        end else begin
            acc_a <= next_acc_a;
            acc_b <= next_acc_b;
            mul_result <= next_mul_result;
            x_rd_en <= next_x_rd_en;
            y_rd_en <= next_y_rd_en;
            x_rd_addr <= next_x_rd_addr;
            y_rd_addr <= next_y_rd_addr;
            x_ptr <= next_x_ptr;
            y_ptr <= next_y_ptr;
            wb_we <= next_wb_we;
            wb_addr <= next_wb_addr;
            wb_data <= next_wb_data;
        end
    end

    // ------------------------------------------------------------
    // Prefetch data return into working registers
    // ------------------------------------------------------------
    logic next_reg_we_x;
    logic next_reg_we_y;
    logic [3:0] next_reg_waddr_x;
    logic [3:0] next_reg_waddr_y;
    logic [15:0] next_reg_wdata_x;
    logic [15:0] next_reg_wdata_y;
    logic [3:0] next_x_dest_q;
    logic [3:0] next_y_dest_q;
    always_comb begin
        next_x_dest_q = x_do ? x_dest : x_dest_q; // RQ6
        next_y_dest_q = y_do ? y_dest : y_dest_q; // RQ7
        x_pend = x_rd_en;
        y_pend = y_rd_en;
        next_reg_we_x = x_pend; // RQ9
        next_reg_waddr_x = x_pend ? x_dest_q : reg_waddr_x;
        next_reg_wdata_x = x_pend ? x_rdata : reg_wdata_x;
        next_reg_we_y = y_pend; // RQ9
        next_reg_waddr_y = y_pend ? y_dest_q : reg_waddr_y;
        next_reg_wdata_y = y_pend ? y_rdata : reg_wdata_y;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            x_dest_q <= 4'h0;
            y_dest_q <= 4'h0;
            reg_we_x <= 1'b0;
            reg_we_y <= 1'b0;
            reg_waddr_x <= 4'h0;
            reg_waddr_y <= 4'h0;
            reg_wdata_x <= 16'h0000;
            reg_wdata_y <= 16'h0000;
        end else begin
            x_dest_q <= next_x_dest_q;
            y_dest_q <= next_y_dest_q;
            reg_we_x <= next_reg_we_x;
            reg_we_y <= next_reg_we_y;
            reg_waddr_x <= next_reg_waddr_x;
            reg_waddr_y <= next_reg_waddr_y;
            reg_wdata_x <= next_reg_wdata_x;
            reg_wdata_y <= next_reg_wdata_y;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_x_issue;
        issue && x_fetch;
    endsequence
    sequence s_x_write;
        reg_we_x && reg_waddr_x == $past(x_dest, 2);
    endsequence
    a_prefetch_keeps_acc: assert property ( // RQ1
        issue && op == dmp_op_prefetch |=> acc_a == $past(acc_a) && acc_b == $past(acc_b))
        else $error("prefetch changed acc");
    a_mpy_loads_prod: assert property ( // RQ2
        issue && op == dmp_op_mpy && !acc_sel |=> acc_a == 40'($past(prod)))
        else $error("mpy wrong");
    a_mpyn_negates: assert property ( // RQ3
        issue && op == dmp_op_mpyn && acc_sel |=> acc_b == 40'(-$past(prod)))
        else $error("mpyn wrong");
    a_msc_subtracts: assert property ( // RQ4
        issue && op == dmp_op_msc && !acc_sel |=> acc_a == 40'($past(acc_a) - $past(prod)))
        else $error("msc wrong");
    a_mac_adds: assert property ( // RQ14
        issue && op == dmp_op_mac && acc_sel |=> acc_b == 40'($past(acc_b) + $past(prod)))
        else $error("mac wrong");
    a_x_ptr_step: assert property ( // RQ5
        issue && x_fetch && !x_inc_sel_reg && x_inc_lit == 4'h2 |=> x_ptr == 16'($past(x_ptr) + 16'h0002))
        else $error("x step");
    a_no_x_access: assert property ( // RQ6
        !(issue && x_fetch) |=> !x_rd_en && x_ptr == $past(x_ptr))
        else $error("x access");
    a_no_y_access: assert property ( // RQ7
        !(issue && y_fetch) |=> !y_rd_en && y_ptr == $past(y_ptr))
        else $error("y access");
    a_x_read_addr: assert property ( // RQ15
        issue && x_fetch |=> x_rd_en && x_rd_addr == $past(x_ptr))
        else $error("x addr");
    a_x_dest_write: assert property ( // RQ9
        s_x_issue |=> ##1 s_x_write)
        else $error("x dest");
    a_wb_other_acc: assert property ( // RQ10
        issue && wb_en && op == dmp_op_mac && !acc_sel |=> wb_we && wb_data == $past(acc_b[31:16]))
        else $error("wb");
    a_mulsu_result: assert property ( // RQ12
        issue && op == dmp_op_mulsu |=> mul_result == $past(prod_su))
        else $error("mulsu");
endmodule : dmp_mac_datapath

// >>> dmp_mem_model.sv
// Behavioural data memory answering prefetch reads
module dmp_mem_model #(
    parameter logic [15:0] SALT = 16'h0000
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [15:0] rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] last;
    // Released bus shows the inverse of the last word
    always_comb begin
        rdata = rd_en ? (rd_addr ^ SALT) : ~last;
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            last <= 16'h0000;
        end else if (rd_en) begin
            last <= rd_addr ^ SALT;
        end
    end
endmodule : dmp_mem_model

// >>> dsp_mac_prefetch_datapath_test.sv
// Self-checking bench for the multiply-accumulate datapath
module dsp_mac_prefetch_datapath_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dmp_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, issue = 1'b0, acc_sel = 1'b0, use_imm_b = 1'b0, wb_en = 1'b0;
    logic x_fetch = 1'b0, x_inc_sel_reg = 1'b0, y_fetch = 1'b0, y_inc_sel_reg = 1'b0;
    dmp_op_t op = dmp_op_prefetch;
    logic [15:0] opnd_a = 16'h0000, opnd_b = 16'h0000, imm_b = 16'h0000, x_inc_reg = 16'h0000;
    logic [15:0] y_inc_reg = 16'h0000, x_rdata, y_rdata, x_rd_addr, y_rd_addr, x_ptr, y_ptr;
    logic [15:0] reg_wdata_x, reg_wdata_y, wb_data, m_xptr = 16'h0000, m_yptr = 16'h0000;
    logic [3:0] x_inc_lit = 4'h0, y_inc_lit = 4'h0, x_dest = 4'h5, y_dest = 4'ha, acc_writeback_target = 4'h9;
    logic x_rd_en, y_rd_en, reg_we_x, reg_we_y, wb_we;
    logic [3:0] reg_waddr_x, reg_waddr_y, wb_addr;
    logic [39:0] acc_a, acc_b, m_acc_a = 40'h0, m_acc_b = 40'h0;
    logic [31:0] mul_result, m_mul = 32'h0;
    int err_total = 0, check_count = 0;

    dmp_mac_datapath dut_u (.clock(clock), .resetn(resetn), .issue(issue), .op(op), .acc_sel(acc_sel),
        .opnd_a(opnd_a), .opnd_b(opnd_b), .imm_b(imm_b), .use_imm_b(use_imm_b), .x_fetch(x_fetch),
        .x_inc_sel_reg(x_inc_sel_reg), .x_inc_lit(x_inc_lit), .x_inc_reg(x_inc_reg), .x_dest(x_dest),
        .y_fetch(y_fetch), .y_inc_lit(y_inc_lit), .y_inc_sel_reg(y_inc_sel_reg), .y_inc_reg(y_inc_reg),
        .y_dest(y_dest), .wb_en(wb_en), .acc_writeback_target(acc_writeback_target), .x_rdata(x_rdata),
        .y_rdata(y_rdata), .x_rd_en(x_rd_en), .x_rd_addr(x_rd_addr), .y_rd_en(y_rd_en),
        .y_rd_addr(y_rd_addr), .x_ptr(x_ptr), .y_ptr(y_ptr), .acc_a(acc_a), .acc_b(acc_b),
        .mul_result(mul_result), .reg_we_x(reg_we_x), .reg_waddr_x(reg_waddr_x), .reg_wdata_x(reg_wdata_x),
        .reg_we_y(reg_we_y), .reg_waddr_y(reg_waddr_y), .reg_wdata_y(reg_wdata_y), .wb_we(wb_we),
        .wb_addr(wb_addr), .wb_data(wb_data));
    dmp_mem_model #(.SALT(16'h5a00)) x_mem_u (.clock(clock), .resetn(resetn), .rd_en(x_rd_en),
        .rd_addr(x_rd_addr), .rdata(x_rdata));
    dmp_mem_model #(.SALT(16'ha500)) y_mem_u (.clock(clock), .resetn(resetn), .rd_en(y_rd_en),
        .rd_addr(y_rd_addr), .rdata(y_rdata));

    initial begin
        forever #50 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up;
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : wrap_up

    // ----------------------------------------
    // One instruction with model and checks
    // ----------------------------------------
    task automatic run(input dmp_op_t o, input logic sel, input logic [15:0] a, input logic [15:0] b,
        input logic xf, input logic [3:0] xl, input logic yf, input logic [3:0] yl, input logic wb);
        logic signed [31:0] sa, sb, p;
        logic [39:0] e;
        logic [15:0] bb, xo, yo, ow;
        logic w;
        @(posedge clock);
        op <= o;
        acc_sel <= sel;
        opnd_a <= a;
        opnd_b <= b;
        x_fetch <= xf;
        x_inc_lit <= xl;
        y_fetch <= yf;
        y_inc_lit <= yl;
        wb_en <= wb;
        issue <= 1'b1;
        sa = {{16{a[15]}}, a};
        bb = (o == dmp_op_mulsu && use_imm_b) ? imm_b : b;
        sb = (o == dmp_op_mulsu) ? {16'h0000, bb} : {{16{bb[15]}}, bb};
        p = sa * sb;
        e = sel ? m_acc_b : m_acc_a;
        case (o)
            dmp_op_mpy: e = {{8{p[31]}}, p};
            dmp_op_mpyn: e = -{{8{p[31]}}, p};
            dmp_op_msc: e = e - {{8{p[31]}}, p};
            dmp_op_mac: e = e + {{8{p[31]}}, p};
            dmp_op_mulss, dmp_op_mulsu: m_mul = p;
            default: ;
        endcase
        if (sel) m_acc_b = e; else m_acc_a = e;
        ow = sel ? m_acc_a[31:16] : m_acc_b[31:16];
        xo = m_xptr;
        yo = m_yptr;
        if (xf) m_xptr = xo + (x_inc_sel_reg ? x_inc_reg : {{12{xl[3]}}, xl});
        if (yf) m_yptr = yo + (y_inc_sel_reg ? y_inc_reg : {{12{yl[3]}}, yl});
        w = wb && (o == dmp_op_prefetch || o == dmp_op_msc || o == dmp_op_mac);
        @(posedge clock);
        issue <= 1'b0;
        #1;
        chk("acc_a", acc_a, m_acc_a);
        chk("acc_b", acc_b, m_acc_b);
        if (o == dmp_op_mulss || o == dmp_op_mulsu) chk("mul", mul_result, m_mul);
        chk("x_rd_en", x_rd_en, xf);
        chk("y_rd_en", y_rd_en, yf);
        if (xf) chk("x_rd_addr", x_rd_addr, xo);
        if (yf) chk("y_rd_addr", y_rd_addr, yo);
        chk("x_ptr", x_ptr, m_xptr);
        chk("y_ptr", y_ptr, m_yptr);
        chk("wb_we", wb_we, w);
        if (w) chk("wb", {wb_addr, wb_data}, {acc_writeback_target, ow});
        @(posedge clock);
        #1;
        chk("reg_we_x", reg_we_x, xf);
        chk("reg_we_y", reg_we_y, yf);
        if (xf) chk("reg_x", {reg_waddr_x, reg_wdata_x}, {x_dest, xo ^ 16'h5a00});
        if (yf) chk("reg_y", {reg_waddr_y, reg_wdata_y}, {y_dest, yo ^ 16'ha500});
    endtask : run

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_mac;
        run(dmp_op_mac, 1'b0, 16'h0003, 16'hfffe, 1'b1, 4'h2, 1'b1, 4'ha, 1'b0);
        run(dmp_op_mac, 1'b1, 16'h8000, 16'h0002, 1'b1, 4'he, 1'b0, 4'h0, 1'b1);
        run(dmp_op_mac, 1'b0, 16'h0010, 16'h0010, 1'b0, 4'h0, 1'b0, 4'h0, 1'b1);
    endtask : t_mac

    task automatic t_mpy;
        run(dmp_op_mpy, 1'b1, 16'h7fff, 16'h7fff, 1'b0, 4'h6, 1'b0, 4'h6, 1'b1);
        run(dmp_op_mpy, 1'b1, 16'h4000, 16'h0004, 1'b0, 4'h2, 1'b0, 4'h2, 1'b0);
        run(dmp_op_mpy, 1'b0, 16'hfff0, 16'h0003, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
    endtask : t_mpy

    task automatic t_msc;
        x_inc_sel_reg <= 1'b1;
        x_inc_reg <= 16'h0010;
        y_inc_sel_reg <= 1'b1;
        y_inc_reg <= 16'hfff8;
        x_dest <= 4'h3;
        run(dmp_op_msc, 1'b0, 16'hfffc, 16'h0005, 1'b1, 4'h0, 1'b1, 4'h6, 1'b1);
        x_dest <= 4'h5;
        x_inc_sel_reg <= 1'b0;
        y_inc_sel_reg <= 1'b0;
    endtask : t_msc

    task automatic t_mpyn_pref;
        run(dmp_op_mpyn, 1'b0, 16'h0005, 16'h0003, 1'b1, 4'h4, 1'b1, 4'he, 1'b0);
        run(dmp_op_mpyn, 1'b1, 16'h0007, 16'hfff9, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
        run(dmp_op_prefetch, 1'b1, 16'h1234, 16'h5678, 1'b1, 4'h6, 1'b1, 4'h0, 1'b1);
        run(dmp_op_prefetch, 1'b0, 16'h1234, 16'h5678, 1'b0, 4'hc, 1'b1, 4'hc, 1'b1);
    endtask : t_mpyn_pref

    task automatic t_mul;
        run(dmp_op_mulss, 1'b0, 16'hfffd, 16'h0005, 1'b1, 4'h2, 1'b0, 4'h2, 1'b1);
        run(dmp_op_mulsu, 1'b1, 16'hffff, 16'hffff, 1'b0, 4'h2, 1'b1, 4'h2, 1'b0);
        use_imm_b <= 1'b1;
        imm_b <= 16'h8000;
        run(dmp_op_mulsu, 1'b0, 16'h0002, 16'h1111, 1'b0, 4'h0, 1'b0, 4'h0, 1'b0);
        use_imm_b <= 1'b0;
    endtask : t_mul

    initial begin
        #200000;
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        t_mac();
        t_mpy();
        t_msc();
        t_mpyn_pref();
        t_mul();
        wrap_up();
    end
endmodule : dsp_mac_prefetch_datapath_test
